// File: core/sfd_defines.vh
/*
  Constants of the fault diagnosis readback block: frame layout,
  field positions, reset values and frame length.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SFD_DEFINES_VH
`define SFD_DEFINES_VH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SFD_FRAME_BITS      5'h10
`define SFD_CNT_MAX         5'h11
`define SFD_MON_SETTLE      2'h2
`define SFD_SEL_HI          15
`define SFD_SEL_LO          14
`define SFD_SEL_DIAG        2'h0
`define SFD_RD_SEL_BIT      13
`define SFD_NO_WRITE_BIT    12
`define SFD_MODE_HI         11
`define SFD_MODE_LO         0

// ----------------------------------------------------------------
// Diagnosis field positions
// ----------------------------------------------------------------
`define SFD_GND_BIT         11
`define SFD_BUS_HI          10
`define SFD_BUS_LO          7
`define SFD_SW_HI           6
`define SFD_SW_LO           5
`define SFD_AUX_OK_BIT      4
`define SFD_XCVR_OK_BIT     3
`define SFD_MICRO_OK_BIT    2
`define SFD_XMODE_HI        1
`define SFD_XMODE_LO        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFD_RST_MICRO_OK    1'h1
`define SFD_RST_WORD        16'h0000
`define SFD_RST_MODE        12'h000
`define SFD_RST_CNT         5'h00
`define SFD_RST_CODE        11'h000
`define SFD_RST_SETTLE      2'h0

`endif

// File: core/sfd_sync.v
/*
  Two flip-flop synchroniser for a group of asynchronous levels.
  Assumes each bit is a level held for many clock cycles.
*/
`timescale 1ns/1ps
module sfd_sync #(
  parameter       W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_nrst,
  // Data
  input  wire [W-1:0] i_d,
  output reg  [W-1:0] o_q
);

  reg [W-1:0] meta_q;

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_q <= RST;
      o_q    <= RST;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule // sfd_sync

// File: core/sfd_diag.v
/*
  Fault diagnosis readback register behind the serial interface.
  Serial pins and monitor levels are asynchronous; all are
  synchronised to I_REF_CLK. Serial mode: SDI sampled on SCK rise,
  SDO changes on SCK fall, MSB first, chip select active low.
  Monitor codes are qualified by a settle count before use.
*/
`timescale 1ns/1ps
`include "sfd_defines.vh"

// Notes on behaviour
// - No-write flag set: read only, mode kept
// - No-write flag clear: read and write mode
// - Bit 11 reports ground offset fault
// - Bus fault code bits 10..7, clamp faults
// - Bus fault code wiring faults, 0000 none
// - Bits 6..5 report single wire fault code
// - Third regulator ok flag, 0 on overload
// - Bit 3 reports transceiver regulator health
// - Bit 2 latches supply dip, set on read
// - Bits 1..0 report transceiver mode code
// - Register readable in every operating mode
// - Transceiver regulator flag returns when reactivated
module sfd_diag (
  // Clock and reset
  input  wire        I_REF_CLK,
  input  wire        I_NRST,
  // Serial interface pins
  input  wire        I_SCK,
  input  wire        I_SCS_N,
  input  wire        I_SDI,
  output reg         O_SDO,
  output reg         O_SDO_OE,
  // Monitor levels
  input  wire        I_GROUND_OFFSET_FAULT,
  input  wire [3:0]  I_BUS_FAULT_CODE,
  input  wire [1:0]  I_SINGLE_WIRE_FAULT_CODE,
  input  wire        I_THIRD_REGULATOR_OK,
  input  wire        I_TRANSCEIVER_REGULATOR_OK,
  input  wire        I_MICRO_SUPPLY_LOW,
  input  wire [1:0]  I_TRANSCEIVER_MODE_CODE,
  // Mode register write
  output reg         O_MODE_WR,
  output reg  [11:0] O_MODE_DATA,
  // Frame status
  output reg         O_DIAG_READ,
  output reg         O_FRAME_DISCARD
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  wire [2:0]  pins_s;
  wire [11:0] mon_s;
  wire [10:0] mon_code;
  wire        sck_s;
  wire        cs_n_s;
  wire        sdi_s;
  wire        gnd_s;
  wire [3:0]  bus_s;
  wire [1:0]  sw_s;
  wire        aux_ok_s;
  wire        xcvr_ok_s;
  wire        micro_low_s;
  wire [1:0]  xmode_s;

  // Pins reset to idle levels, clock low and select high,
  // so no false edge follows reset.
  sfd_sync #(
    .W   (3),
    .RST (3'h2)
  ) u_pin_sync (
    .i_clk  (I_REF_CLK),
    .i_nrst (I_NRST),
    .i_d    ({I_SCK, I_SCS_N, I_SDI}),
    .o_q    (pins_s)
  );

  // Monitor levels in the bit order of the diagnosis word
  sfd_sync #(
    .W   (12),
    .RST (12'h000)
  ) u_mon_sync (
    .i_clk  (I_REF_CLK),
    .i_nrst (I_NRST),
    .i_d    ({I_GROUND_OFFSET_FAULT, I_BUS_FAULT_CODE,
              I_SINGLE_WIRE_FAULT_CODE, I_THIRD_REGULATOR_OK,
              I_TRANSCEIVER_REGULATOR_OK, I_MICRO_SUPPLY_LOW,
              I_TRANSCEIVER_MODE_CODE}),
    .o_q    (mon_s)
  );

  assign sck_s       = pins_s[2];
  assign cs_n_s      = pins_s[1];
  assign sdi_s       = pins_s[0];
  assign micro_low_s = mon_s[2];
  assign mon_code    = {mon_s[11:3], mon_s[1:0]};

  // ----------------------------------------------------------------
  // Monitor code qualification
  // ----------------------------------------------------------------
  // Codes are synchronised bit by bit and may tear while changing.
  // A code is taken only after standing unchanged for a few cycles.
  // Codes that never settle keep the last settled value.
  // The supply dip level bypasses this so no dip is ever missed.
  reg  [10:0] code_prev_q;
  reg  [10:0] code_hold_q;
  reg  [1:0]  settle_q;
  wire        code_same;

  assign code_same = (mon_code == code_prev_q);

  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      code_prev_q <= `SFD_RST_CODE;
      code_hold_q <= `SFD_RST_CODE;
      settle_q    <= `SFD_RST_SETTLE;
    end else begin
      code_prev_q <= mon_code;
      if (!code_same) begin
        settle_q <= `SFD_RST_SETTLE;
      end else if (settle_q != `SFD_MON_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end else begin
        // Copied every cycle once settled
        code_hold_q <= mon_code;
      end
    end
  end

  assign gnd_s       = code_hold_q[10];
  assign bus_s       = code_hold_q[9:6];
  assign sw_s        = code_hold_q[5:4];
  assign aux_ok_s    = code_hold_q[3];
  assign xcvr_ok_s   = code_hold_q[2];
  assign xmode_s     = code_hold_q[1:0];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Serial clock edges count only while the frame is open;
  // frame start and end come from the select alone.
  reg  sck_q;
  reg  cs_n_q;
  wire sck_rise;
  wire sck_fall;
  wire cs_start;
  wire cs_end;
  wire active;

  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      sck_q  <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q  <= sck_s;
      cs_n_q <= cs_n_s;
    end
  end

  assign active   = ~cs_n_q;
  assign sck_rise = active & sck_s & ~sck_q;
  assign sck_fall = active & ~sck_s & sck_q;
  assign cs_start = cs_n_q & ~cs_n_s;
  assign cs_end   = ~cs_n_q & cs_n_s;

  // ----------------------------------------------------------------
  // Live diagnosis word
  // ----------------------------------------------------------------
  // Assembled continuously; captured into the shift register
  // only at frame start.
  reg         micro_ok_q;
  reg         dip_since_snap_q;
  wire [15:0] diag_word;

  // Bits 15 to 12 carry no field and read as zero
  assign diag_word[15:12]                     = 4'h0;
  assign diag_word[`SFD_GND_BIT]              = gnd_s;
  assign diag_word[`SFD_BUS_HI:`SFD_BUS_LO]   = bus_s;
  assign diag_word[`SFD_SW_HI:`SFD_SW_LO]     = sw_s;
  assign diag_word[`SFD_AUX_OK_BIT]           = aux_ok_s;
  assign diag_word[`SFD_XCVR_OK_BIT]          = xcvr_ok_s;
  assign diag_word[`SFD_MICRO_OK_BIT]         = micro_ok_q;
  assign diag_word[`SFD_XMODE_HI:`SFD_XMODE_LO] = xmode_s;

  // ----------------------------------------------------------------
  // Shift registers and frame counter
  // ----------------------------------------------------------------
  // Receive shifts on rising edges, transmit on falling edges;
  // the first output bit is loaded with the snapshot itself.
  reg [15:0] tx_q;
  reg [15:0] tx_d;
  reg [15:0] rx_q;
  reg [15:0] rx_d;
  reg [4:0]  cnt_q;
  reg [4:0]  cnt_d;
  reg        sdo_d;

  always @* begin
    tx_d  = tx_q;
    rx_d  = rx_q;
    cnt_d = cnt_q;
    sdo_d = O_SDO;
    if (cs_start) begin
      // Snapshot of every field, first bit driven at once
      tx_d  = diag_word;
      sdo_d = diag_word[15];
      cnt_d = `SFD_RST_CNT;
    end else begin
      if (sck_rise) begin
        rx_d = {rx_q[14:0], sdi_s};
        // Saturates so an overlong frame stays invalid
        if (cnt_q != `SFD_CNT_MAX) begin
          cnt_d = cnt_q + 5'h01;
        end
      end
      if (sck_fall) begin
        tx_d  = {tx_q[14:0], 1'b0};
        sdo_d = tx_q[14];
      end
    end
  end

  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      tx_q     <= `SFD_RST_WORD;
      rx_q     <= `SFD_RST_WORD;
      cnt_q    <= `SFD_RST_CNT;
      O_SDO    <= 1'b0;
      O_SDO_OE <= 1'b0;
    end else begin
      tx_q     <= tx_d;
      rx_q     <= rx_d;
      cnt_q    <= cnt_d;
      O_SDO    <= sdo_d;
      // Released as soon as the synchronised select rises
      O_SDO_OE <= ~cs_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Frame decode at chip select release
  // ----------------------------------------------------------------
  // Decided once, at select release, from the received word
  // and the count of rising clock edges.
  wire frame_ok;
  wire diag_sel;
  wire diag_hit;
  wire no_write;
  wire mode_wr;

  assign frame_ok = (cnt_q == `SFD_FRAME_BITS);
  assign diag_sel = (rx_q[`SFD_SEL_HI:`SFD_SEL_LO] == `SFD_SEL_DIAG)
                  & rx_q[`SFD_RD_SEL_BIT];
  assign diag_hit = cs_end & frame_ok & diag_sel;
  assign no_write = rx_q[`SFD_NO_WRITE_BIT];
  assign mode_wr  = diag_hit & ~no_write;

  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_MODE_WR       <= 1'b0;
      O_MODE_DATA     <= `SFD_RST_MODE;
      O_DIAG_READ     <= 1'b0;
      O_FRAME_DISCARD <= 1'b0;
    end else begin
      // Pulses last one cycle
      O_DIAG_READ     <= diag_hit;
      O_FRAME_DISCARD <= cs_end & ~frame_ok;
      O_MODE_WR       <= mode_wr;
      // Mode data moves only together with a write pulse
      if (mode_wr) begin
        O_MODE_DATA <= rx_q[`SFD_MODE_HI:`SFD_MODE_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Supply dip latch, restored by a completed read
  // ----------------------------------------------------------------
  // A dip after the snapshot is kept for the next read.
  // A supply still low at the end of a read keeps the flag
  // at zero: the failure wins over the read.
  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      micro_ok_q       <= `SFD_RST_MICRO_OK;
      dip_since_snap_q <= 1'b0;
    end else begin
      // Snapshot restarts the dip record for the frame just opened
      if (cs_start) begin
        dip_since_snap_q <= micro_low_s;
      end else if (micro_low_s) begin
        dip_since_snap_q <= 1'b1;
      end
      if (micro_low_s) begin
        micro_ok_q <= 1'b0;
      end else if (diag_hit) begin
        micro_ok_q <= ~dip_since_snap_q;
      end
    end
  end

endmodule // sfd_diag

// File: bench/sfd_diag_asserts.sv
/* Checker for the sfd_diag frame status and pin enable outputs.
   Bound to sfd_diag; sees only that module's ports. */
`timescale 1ns/1ps
module sfd_diag_asserts (
  input wire        I_REF_CLK,
  input wire        I_NRST,
  input wire        I_SCS_N,
  input wire        O_SDO_OE,
  input wire        O_MODE_WR,
  input wire [11:0] O_MODE_DATA,
  input wire        O_DIAG_READ,
  input wire        O_FRAME_DISCARD
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  a_write_needs_read: assert property (
    O_MODE_WR |-> O_DIAG_READ) else $error("write without read");
  a_discard_alone: assert property (
    O_FRAME_DISCARD |-> !O_DIAG_READ && !O_MODE_WR)
    else $error("discarded frame had side effect");
  a_data_on_write: assert property (
    $changed(O_MODE_DATA) |-> O_MODE_WR) else $error("mode data moved");
  a_read_after_end: assert property (
    O_DIAG_READ |-> $past(I_SCS_N, 3)) else $error("read inside frame");
  a_discard_after_end: assert property (
    O_FRAME_DISCARD |-> $past(I_SCS_N, 3)) else $error("early discard");
  a_read_pulse_once: assert property (
    O_DIAG_READ |=> !O_DIAG_READ) else $error("read pulse too long");
  a_oe_in_frame: assert property (
    !I_SCS_N [*6] |-> O_SDO_OE) else $error("output not enabled");
  a_oe_when_idle: assert property (
    I_SCS_N [*7] |-> !O_SDO_OE) else $error("output enabled when idle");
endmodule // sfd_diag_asserts

bind sfd_diag sfd_diag_asserts u_chk (
  .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_SCS_N(I_SCS_N),
  .O_SDO_OE(O_SDO_OE), .O_MODE_WR(O_MODE_WR), .O_MODE_DATA(O_MODE_DATA),
  .O_DIAG_READ(O_DIAG_READ), .O_FRAME_DISCARD(O_FRAME_DISCARD)
);

// File: bench/sfd_host.sv
/* Host model: serial master, 125 ns clock, idle low between frames.
   Assumes i_clk is the 5 ns reference; tasks start at a falling edge. */
`timescale 1ns/1ps
module sfd_host (
  input  wire i_clk,
  input  wire i_sdo,
  input  wire i_sdo_oe,
  output reg  o_sck,
  output reg  o_scs_n,
  output reg  o_sdi
);
  initial begin
    o_sck = 1'b0;
    o_scs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // Frame of n clocks, MSB first; sampled reply in r
  task frame(input [15:0] w, input integer n, output [15:0] r);
    integer i;
    begin
      o_scs_n = 1'b0;
      repeat (12) @(negedge i_clk);
      for (i = 0; i < n; i = i + 1) begin
        o_sdi = w[15 - i % 16];
        repeat (13) @(negedge i_clk);
        o_sck = 1'b1;
        r = {r[14:0], i_sdo_oe ? i_sdo : 1'bx};
        repeat (12) @(negedge i_clk);
        o_sck = 1'b0;
      end
      repeat (13) @(negedge i_clk);
      o_scs_n = 1'b1;
      o_sdi = ~o_sdi;
      repeat (10) @(negedge i_clk);
    end
  endtask
endmodule // sfd_host

// File: bench/tb_top.sv
/* Self-checking bench for sfd_diag with a serial host model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module tb_top;
  reg         clk = 0, nrst = 0, gnd = 0, aux = 1, xok = 1, low = 0;
  reg  [3:0]  bus = 0;
  reg  [1:0]  sw = 0, md = 0;
  reg  [15:0] r, w;
  reg  [11:0] em = 12'h000;
  wire        sck, cs_n, sdi, sdo, oe, wr, rd, dis;
  wire [11:0] mdat;
  integer     mismatches = 0, checks = 0, cyc = 0;
  integer     nrd = 0, nwr = 0, ndis = 0, k;
  initial forever #2.5 clk = ~clk;
  sfd_diag dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_SCK(sck),
    .I_SCS_N(cs_n), .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(oe),
    .I_GROUND_OFFSET_FAULT(gnd), .I_BUS_FAULT_CODE(bus),
    .I_SINGLE_WIRE_FAULT_CODE(sw), .I_THIRD_REGULATOR_OK(aux),
    .I_TRANSCEIVER_REGULATOR_OK(xok), .I_MICRO_SUPPLY_LOW(low),
    .I_TRANSCEIVER_MODE_CODE(md), .O_MODE_WR(wr), .O_MODE_DATA(mdat),
    .O_DIAG_READ(rd), .O_FRAME_DISCARD(dis));
  sfd_host host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(oe), .o_sck(sck),
    .o_scs_n(cs_n), .o_sdi(sdi));
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    nrd <= nrd + rd;
    nwr <= nwr + wr;
    ndis <= ndis + dis;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, s, e);
      end
    end
  endtask
  function [15:0] expw(input m);
    expw = {4'h0, gnd, bus, sw, aux, xok, m, md};
  endfunction
  // Frame, then compare pulse counts as read/write/discard nibbles
  task frm(input [15:0] fw, input integer n, input [11:0] e);
    integer a, b, c;
    begin
      a = nrd;
      b = nwr;
      c = ndis;
      repeat (10) @(negedge clk);
      host.frame(fw, n, r);
      chk(((nrd - a) << 8) | ((nwr - b) << 4) | (ndis - c), e);
    end
  endtask
  initial begin
    k = $urandom(68122);
    repeat (4) @(negedge clk);
    nrst = 1;
    repeat (6) @(negedge clk);
    for (k = 0; k < 16; k = k + 1) begin
      gnd = $urandom;
      aux = $urandom;
      xok = $urandom;
      bus = k[3:0];
      sw = k[1:0];
      md = k[3:2];
      w = $urandom;
      w[15:12] = {3'b001, k[0]};
      frm(w, 16, k[0] ? 12'h100 : 12'h110);
      chk(r, expw(1'b1));
      if (!k[0]) em = w[11:0];
      chk(mdat, em);
      $display("test code %0d done", k);
    end
    low = 1;
    repeat (10) @(negedge clk);
    low = 0;
    frm(16'h3000, 16, 12'h100);
    chk(r[2], 1'b0);
    frm(16'h3000, 16, 12'h100);
    chk(r[2], 1'b1);
    $display("test supply dip done");
    xok = 1'b0;
    frm(16'h3000, 16, 12'h100);
    chk(r[3], 1'b0);
    xok = 1'b1;
    frm(16'h3000, 16, 12'h100);
    chk(r[3], 1'b1);
    $display("test regulator return done");
    low = 1;
    repeat (10) @(negedge clk);
    low = 0;
    nrst = 0;
    repeat (4) @(negedge clk);
    chk({oe, wr, rd, dis, mdat}, 16'h0000);
    nrst = 1;
    repeat (6) @(negedge clk);
    frm(16'h3000, 16, 12'h100);
    chk(r[2], 1'b1);
    frm(16'h2a5c, 16, 12'h110);
    em = 12'ha5c;
    chk(mdat, em);
    $display("test mid-run reset done");
    frm(16'h2000, 15, 12'h001);
    frm(16'h2000, 17, 12'h001);
    frm(16'h6000, 16, 12'h000);
    frm(16'h0000, 16, 12'h000);
    chk(mdat, em);
    $display("test refused frames done");
    summarize;
  end
endmodule // tb_top
